// *** hw/bsd_pkg.sv ***
// Package for the boot strap decoder: field positions, codes and types.
// Assumes a single 50 MHz clock domain and a synchronous active-high reset.
package bsd_pkg;
   localparam int STRAP_W        = 14;
   localparam int BANK_W         = 8;
   localparam int PLL_LSB        = 0;
   localparam int PRI_LSB        = 3;
   localparam int OPT_LSB        = 7;
   localparam int BAK_LSB        = 10;
   localparam int BAK_OPT_BIT    = 13;
   localparam logic [STRAP_W-1:0] STRAP_RST = 14'h0000;
   localparam logic [2:0] PLL_24 = 3'h2;
   localparam logic [2:0] PLL_25 = 3'h3;
   localparam logic [2:0] PLL_26 = 3'h4;
   localparam int I2C_ADDR_LO    = 8'h50;
   localparam int I2C_ADDR_HI    = 8'h51;
   localparam int XSPI_OP_LO     = 8'h0B;
   localparam int XSPI_OP_HI     = 8'hEE;
   localparam int I2C_HUNG_US    = 1000;
   localparam int CLK_MHZ        = 50;
   localparam int I2C_HUNG_CYC   = I2C_HUNG_US * CLK_MHZ;

   typedef enum logic [1:0] {
      BSD_REF_RSVD, BSD_REF_24, BSD_REF_25, BSD_REF_26
   } bsd_ref_t;

   typedef enum logic [3:0] {
      BSD_P_SNAND, BSD_P_OSPI, BSD_P_QSPI, BSD_P_SPI,
      BSD_P_RGMII, BSD_P_RMII, BSD_P_I2C, BSD_P_UART,
      BSD_P_SD, BSD_P_MMC, BSD_P_USB, BSD_P_RSV0,
      BSD_P_RSV1, BSD_P_FXSPI, BSD_P_XSPI, BSD_P_NOBOOT
   } bsd_pri_t;

   typedef enum logic [2:0] {
      BSD_B_NONE, BSD_B_USB, BSD_B_RSV, BSD_B_UART,
      BSD_B_ETH, BSD_B_SD, BSD_B_SPI, BSD_B_I2C
   } bsd_bak_t;
endpackage

// *** hw/bsd_if.sv ***
// Interface carrying the latched strap word from the sampler to the decoder.
// Assumes both ends run on mclk.
`timescale 1ns/1ns
interface bsd_if;
   logic [13:0] strap;
   logic        valid;
   modport src (output strap, output valid);
   modport dst (input strap, input valid);
endinterface

// *** hw/bsd_sampler.sv ***
// Strap sampler: synchronises both banks and latches them at reset release.
// Assumes switch levels are static and asynchronous to mclk.
`timescale 1ns/1ns
module bsd_sampler
   import bsd_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               reset,
   input  wire logic [BANK_W-1:0]  low_switch_bank,
   input  wire logic [BANK_W-1:0]  high_switch_bank,
   bsd_if.src                      sb
);
   logic [15:0] s1_r, s2_r;
   logic [1:0]  dly_r;
   logic [13:0] strap_r, strap_nxt;
   logic        valid_r, valid_nxt;

   always_comb
   begin
      strap_nxt = strap_r;
      valid_nxt = valid_r;
      // Two cycles after release both synchroniser stages hold settled levels.
      if (!valid_r && dly_r == 2'h2)
      begin
         strap_nxt = s2_r[STRAP_W-1:0];
         valid_nxt = 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      s1_r <= {high_switch_bank, low_switch_bank};
      s2_r <= s1_r;
      if (reset)
      begin
         dly_r   <= 2'h0;
         strap_r <= STRAP_RST;
         valid_r <= 1'b0;
      end
      else
      begin
         if (dly_r != 2'h2)
            dly_r <= dly_r + 2'h1;
         strap_r <= strap_nxt;
         valid_r <= valid_nxt;
      end
   end

   assign sb.strap = strap_r;
   assign sb.valid = valid_r;

   property p_hold;
      @(posedge mclk) disable iff (reset)
      valid_r |=> (valid_r && $stable(strap_r));
   endproperty
   a_hold: assert property (p_hold)
      else $error("strap changed after latch");
endmodule // bsd_sampler

// *** hw/bsd_top.sv ***
// Boot strap decoder top: turns the latched strap word into boot settings.
// Assumes switch ON reads as 1 and straps are static through reset.
`timescale 1ns/1ns
module bsd_top
   import bsd_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               reset,
   input  wire logic [BANK_W-1:0]  low_switch_bank,
   input  wire logic [BANK_W-1:0]  high_switch_bank,
   output logic                    cfg_valid,
   output bsd_ref_t                pll_ref,
   output bsd_pri_t                primary_src,
   output logic                    nand_width_override,
   output logic                    nand_wide_width_select,
   output logic [1:0]              nand_lanes_log2,
   output logic                    chip_select,
   output logic                    spi_mode3,
   output logic                    link_from_status,
   output logic                    reference_clock_output,
   output logic                    rmii_clock_source,
   output logic                    i2c_bus_reset_en,
   output logic [7:0]              i2c_target_addr,
   output logic [31:0]             i2c_hung_cycles,
   output logic                    filesystem_or_raw_select,
   output logic                    usb_core_low_volt,
   output logic                    usb_dfu,
   output logic                    usb_lane_swap,
   output logic                    xspi_discovery_en,
   output logic [7:0]              xspi_read_opcode,
   output logic                    xspi_ddr_mode,
   output logic                    thumb_mode,
   output logic                    no_boot,
   output bsd_bak_t                backup_src,
   output logic                    backup_opt,
   output logic                    bak_chip_select,
   output logic                    bak_spi_mode3,
   output logic                    bak_i2c_addr_hi,
   output logic                    bak_i2c_bus_reset_skip,
   output logic                    bak_usb_low_volt,
   output logic                    bak_usb_lane_swap,
   output logic                    bak_link_from_status,
   output logic                    bak_clock_output,
   output logic                    bak_clock_source
);
   import bsd_pkg::*;

   bsd_if sb ();

   bsd_sampler u_smp
   (
      .mclk             (mclk),
      .reset            (reset),
      .low_switch_bank  (low_switch_bank),
      .high_switch_bank (high_switch_bank),
      .sb               (sb)
   );

   // Primary options are qualified by the selected source so that bits
   // meaning something else for another source never leak out.
   function automatic logic sel(input bsd_pri_t p, input bsd_pri_t want,
                                input logic b);
      sel = (p == want) ? b : 1'b0;
   endfunction

   typedef struct packed {
      logic       valid;
      bsd_ref_t   pref;
      bsd_pri_t   pri;
      logic       nwo, nws;
      logic [1:0] nl;
      logic       cs, m3, lst, clko, csrc, ibr;
      logic [7:0] ia;
      logic       fsr, ucv, udfu, uls, xd;
      logic [7:0] xo;
      logic       xm, th, nb;
      bsd_bak_t   bak;
      logic       bo;
   } bsd_cfg_t;

   bsd_cfg_t cfg_r, cfg_nxt;
   logic [13:0] w;
   logic b7, b8, b9;
   bsd_pri_t p;

   always_comb
   begin
      w   = sb.strap;
      b7  = w[OPT_LSB];
      b8  = w[OPT_LSB+1];
      b9  = w[OPT_LSB+2];
      p   = bsd_pri_t'(w[PRI_LSB+3:PRI_LSB]);
      cfg_nxt = cfg_r;
      if (sb.valid && !cfg_r.valid)
      begin
         cfg_nxt.valid = 1'b1;
         case (w[PLL_LSB+2:PLL_LSB])
            PLL_24:  cfg_nxt.pref = BSD_REF_24;
            PLL_25:  cfg_nxt.pref = BSD_REF_25;
            PLL_26:  cfg_nxt.pref = BSD_REF_26;
            default: cfg_nxt.pref = BSD_REF_RSVD;
         endcase
         cfg_nxt.pri  = p;
         cfg_nxt.nwo  = sel(p, BSD_P_SNAND, b8);
         cfg_nxt.nws  = sel(p, BSD_P_SNAND, b7 & ~b8);
         cfg_nxt.nl   = (p != BSD_P_SNAND) ? 2'h0 :
                        b8 ? 2'h0 : (b7 ? 2'h2 : 2'h3);
         cfg_nxt.cs   = (p == BSD_P_OSPI || p == BSD_P_QSPI ||
                         p == BSD_P_SPI) ? b7 : 1'b0;
         cfg_nxt.m3   = sel(p, BSD_P_SPI, b8);
         cfg_nxt.lst  = sel(p, BSD_P_RGMII, b7);
         cfg_nxt.clko = sel(p, BSD_P_RMII, b9);
         cfg_nxt.csrc = sel(p, BSD_P_RMII, b8);
         cfg_nxt.ibr  = sel(p, BSD_P_I2C, ~b9);
         cfg_nxt.ia   = (p == BSD_P_I2C && b7) ? 8'(I2C_ADDR_HI)
                                               : 8'(I2C_ADDR_LO);
         cfg_nxt.fsr  = sel(p, BSD_P_SD, b7);
         cfg_nxt.ucv  = sel(p, BSD_P_USB, b9);
         cfg_nxt.udfu = sel(p, BSD_P_USB, ~b8);
         cfg_nxt.uls  = sel(p, BSD_P_USB, b7);
         cfg_nxt.xd   = sel(p, BSD_P_XSPI, b9);
         cfg_nxt.xo   = (p == BSD_P_XSPI && b8) ? 8'(XSPI_OP_HI)
                                                : 8'(XSPI_OP_LO);
         cfg_nxt.xm   = sel(p, BSD_P_XSPI, b7);
         cfg_nxt.th   = sel(p, BSD_P_NOBOOT, b8);
         cfg_nxt.nb   = sel(p, BSD_P_NOBOOT, b7);
         cfg_nxt.bak  = bsd_bak_t'(w[BAK_LSB+2:BAK_LSB]);
         cfg_nxt.bo   = w[BAK_OPT_BIT];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         cfg_r <= '0;
      else
         cfg_r <= cfg_nxt;
   end

   // Backup defaults are constants except bak_clock_source, set when the backup
   // source is BSD_B_ETH; all are registered to keep every output on a flip-flop.
   logic [8:0] bk_r, bk_nxt;
   always_comb
   begin
      bk_nxt = 9'h000;
      bk_nxt[0] = 1'b0;
      bk_nxt[1] = 1'b0;
      bk_nxt[2] = 1'b0;
      bk_nxt[3] = 1'b0;
      bk_nxt[4] = 1'b0;
      bk_nxt[5] = 1'b0;
      bk_nxt[6] = 1'b0;
      bk_nxt[7] = 1'b0;
      bk_nxt[8] = (cfg_r.bak == BSD_B_ETH);
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         bk_r <= 9'h000;
      else
         bk_r <= bk_nxt;
   end

   logic [31:0] hung_r;
   always_ff @(posedge mclk)
   begin
      if (reset)
         hung_r <= 32'h0;
      else
         hung_r <= cfg_r.ibr ? 32'(I2C_HUNG_CYC) : 32'h0;
   end

   assign cfg_valid              = cfg_r.valid;
   assign pll_ref                = cfg_r.pref;
   assign primary_src            = cfg_r.pri;
   assign nand_width_override    = cfg_r.nwo;
   assign nand_wide_width_select = cfg_r.nws;
   assign nand_lanes_log2        = cfg_r.nl;
   assign chip_select            = cfg_r.cs;
   assign spi_mode3              = cfg_r.m3;
   assign link_from_status       = cfg_r.lst;
   assign reference_clock_output = cfg_r.clko;
   assign rmii_clock_source      = cfg_r.csrc;
   assign i2c_bus_reset_en       = cfg_r.ibr;
   assign i2c_target_addr        = cfg_r.ia;
   assign i2c_hung_cycles        = hung_r;
   assign filesystem_or_raw_select = cfg_r.fsr;
   assign usb_core_low_volt      = cfg_r.ucv;
   assign usb_dfu                = cfg_r.udfu;
   assign usb_lane_swap          = cfg_r.uls;
   assign xspi_discovery_en      = cfg_r.xd;
   assign xspi_read_opcode       = cfg_r.xo;
   assign xspi_ddr_mode          = cfg_r.xm;
   assign thumb_mode             = cfg_r.th;
   assign no_boot                = cfg_r.nb;
   assign backup_src             = cfg_r.bak;
   assign backup_opt             = cfg_r.bo;
   assign bak_chip_select        = bk_r[0];
   assign bak_spi_mode3          = bk_r[1];
   assign bak_i2c_addr_hi        = bk_r[2];
   assign bak_i2c_bus_reset_skip = bk_r[3];
   assign bak_usb_low_volt       = bk_r[4];
   assign bak_usb_lane_swap      = bk_r[5];
   assign bak_link_from_status   = bk_r[6];
   assign bak_clock_output       = bk_r[7];
   assign bak_clock_source       = bk_r[8];

   property p_latch;
      @(posedge mclk) disable iff (reset)
      (sb.valid && !cfg_r.valid) |=> (cfg_r.valid && cfg_r.pri ==
         bsd_pri_t'($past(sb.strap[6:3])));
   endproperty
   a_latch: assert property (p_latch)
      else $error("primary not latched");

   property p_pll;
      @(posedge mclk) disable iff (reset)
      (sb.valid && !cfg_r.valid && sb.strap[2:0] == 3'h3) |=>
         (cfg_r.pref == BSD_REF_25);
   endproperty
   a_pll: assert property (p_pll)
      else $error("pll ref wrong");

   property p_nand;
      @(posedge mclk) disable iff (reset)
      (cfg_r.valid && cfg_r.pri == BSD_P_SNAND && cfg_r.nwo) |->
         (cfg_r.nl == 2'h0 && !cfg_r.nws);
   endproperty
   a_nand: assert property (p_nand)
      else $error("nand width wrong");

   // The reset image is all zeros, so the address default only applies
   // once the settings have been latched.
   property p_i2c;
      @(posedge mclk) disable iff (reset)
      (cfg_r.valid && cfg_r.pri != BSD_P_I2C) |->
         (cfg_r.ia == 8'h50 && !cfg_r.ibr);
   endproperty
   a_i2c: assert property (p_i2c)
      else $error("i2c defaults wrong");

   property p_xspi;
      @(posedge mclk) disable iff (reset)
      (cfg_r.valid && cfg_r.xm) |-> (cfg_r.pri == BSD_P_XSPI);
   endproperty
   a_xspi: assert property (p_xspi)
      else $error("xspi mode leak");

   property p_usb;
      @(posedge mclk) disable iff (reset)
      (sb.valid && !cfg_r.valid && sb.strap[6:3] == BSD_P_USB) |=>
         (usb_dfu == !$past(sb.strap[8]));
   endproperty
   a_usb: assert property (p_usb)
      else $error("usb dfu wrong");

   property p_rmii;
      @(posedge mclk) disable iff (reset)
      (sb.valid && !cfg_r.valid && sb.strap[6:3] == BSD_P_RMII) |=>
         (cfg_r.clko == $past(sb.strap[9]) &&
          cfg_r.csrc == $past(sb.strap[8]));
   endproperty
   a_rmii: assert property (p_rmii)
      else $error("rmii options wrong");

   property p_bak;
      @(posedge mclk) disable iff (reset)
      cfg_r.valid |=> $stable(cfg_r.bak) && bk_r[7:0] == 8'h00 &&
         bk_r[8] == (cfg_r.bak == BSD_B_ETH);
   endproperty
   a_bak: assert property (p_bak)
      else $error("backup default wrong");

   // Two synchroniser stages plus the latch put the settings out on the
   // fourth edge after release; anything earlier would read unsettled pins.
   property p_rel;
      @(posedge mclk) disable iff (reset)
      $fell(reset) |-> ##3 !cfg_r.valid ##1 cfg_r.valid;
   endproperty
   a_rel: assert property (p_rel)
      else $error("sample timing wrong");

   property p_hold;
      @(posedge mclk) disable iff (reset)
      cfg_r.valid |=> cfg_r == $past(cfg_r);
   endproperty
   a_hold: assert property (p_hold)
      else $error("config changed");
endmodule // bsd_top

// *** sim/bsd_switch_model.sv ***
// Static boot strap switch model: two banks of DIP switches.
// Assumes the bench sets positions and holds them while they are sampled.
`timescale 1ns/1ns
module bsd_switch_model
(
   input  wire logic [13:0] setting,
   output wire logic [7:0]  low_switch_bank,
   output wire logic [7:0]  high_switch_bank
);
   // ON reads as 1; the two unused top switches stay OFF so that
   // they can never alias into the strap word.
   assign low_switch_bank  = setting[7:0];
   assign high_switch_bank = {2'h0, setting[13:8]};
endmodule // bsd_switch_model

// *** sim/boot_strap_decoder_bench.sv ***
// Self-checking bench for the boot strap decoder top.
// Assumes the switch model in sim/ and the design package bsd_pkg.
`timescale 1ns/1ns
module boot_strap_decoder_bench;
   import bsd_pkg::*;
   logic        mclk, reset, cfg_valid;
   logic [13:0] strap_set;
   logic [7:0]  low_switch_bank, high_switch_bank;
   logic [7:0]  i2c_target_addr, xspi_read_opcode;
   logic [31:0] i2c_hung_cycles;
   logic [1:0]  nand_lanes_log2;
   bsd_ref_t    pll_ref;
   bsd_pri_t    primary_src;
   bsd_bak_t    backup_src;
   logic nand_width_override, nand_wide_width_select, chip_select, spi_mode3;
   logic link_from_status, reference_clock_output, rmii_clock_source;
   logic i2c_bus_reset_en, filesystem_or_raw_select, usb_core_low_volt;
   logic usb_dfu, usb_lane_swap, xspi_discovery_en, xspi_ddr_mode;
   logic thumb_mode, no_boot, backup_opt, bak_chip_select, bak_spi_mode3;
   logic bak_i2c_addr_hi, bak_i2c_bus_reset_skip, bak_usb_low_volt;
   logic bak_usb_lane_swap, bak_link_from_status, bak_clock_output;
   logic bak_clock_source;
   int   fails, samples_checked, cycles;
   localparam int LIMIT = 5000;

   bsd_switch_model i_sw (.setting(strap_set),
      .low_switch_bank(low_switch_bank), .high_switch_bank(high_switch_bank));

   bsd_top i_dut (.mclk(mclk), .reset(reset),
      .low_switch_bank(low_switch_bank), .high_switch_bank(high_switch_bank),
      .cfg_valid(cfg_valid), .pll_ref(pll_ref), .primary_src(primary_src),
      .nand_width_override(nand_width_override),
      .nand_wide_width_select(nand_wide_width_select),
      .nand_lanes_log2(nand_lanes_log2), .chip_select(chip_select),
      .spi_mode3(spi_mode3), .link_from_status(link_from_status),
      .reference_clock_output(reference_clock_output),
      .rmii_clock_source(rmii_clock_source),
      .i2c_bus_reset_en(i2c_bus_reset_en), .i2c_target_addr(i2c_target_addr),
      .i2c_hung_cycles(i2c_hung_cycles),
      .filesystem_or_raw_select(filesystem_or_raw_select),
      .usb_core_low_volt(usb_core_low_volt), .usb_dfu(usb_dfu),
      .usb_lane_swap(usb_lane_swap), .xspi_discovery_en(xspi_discovery_en),
      .xspi_read_opcode(xspi_read_opcode), .xspi_ddr_mode(xspi_ddr_mode),
      .thumb_mode(thumb_mode), .no_boot(no_boot), .backup_src(backup_src),
      .backup_opt(backup_opt), .bak_chip_select(bak_chip_select),
      .bak_spi_mode3(bak_spi_mode3), .bak_i2c_addr_hi(bak_i2c_addr_hi),
      .bak_i2c_bus_reset_skip(bak_i2c_bus_reset_skip),
      .bak_usb_low_volt(bak_usb_low_volt),
      .bak_usb_lane_swap(bak_usb_lane_swap),
      .bak_link_from_status(bak_link_from_status),
      .bak_clock_output(bak_clock_output),
      .bak_clock_source(bak_clock_source));

   always #10 mclk = ~mclk;

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // A hang in any wait loop ends here rather than running forever.
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         fails++;
         $display("mismatch at %0t: cycle limit reached", $time);
         end_of_test();
      end
   end

   task automatic step;
      @(posedge mclk);
      #2;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      samples_checked++;
      if (got !== exp)
         $display("mismatch at %0t: %s got %0h exp %0h", $time, msg, got, exp);
      if (got !== exp)
         fails++;
   endtask

   function automatic logic [13:0] mk(input logic [2:0] pll,
      input logic [3:0] pri, input logic [2:0] opt, input logic [2:0] bak,
      input logic bo);
      return {bo, bak, opt, pri, pll};
   endfunction

   // Derived outputs lag cfg_valid, so two extra edges pass before checks.
   task automatic apply(input logic [13:0] s);
      int n;
      n = 0;
      strap_set = s;
      reset = 1'b1;
      repeat (4) step();
      reset = 1'b0;
      while (cfg_valid !== 1'b1 && n < 10)
      begin
         step();
         n++;
      end
      chk(cfg_valid, 1, "settings not latched");
      repeat (2) step();
   endtask

   task automatic t_pll;
      logic [31:0] e;
      for (int i = 0; i < 8; i++)
      begin
         apply(mk(i[2:0], BSD_P_UART, 3'h0, 3'h0, 1'b0));
         e = (i == PLL_24) ? BSD_REF_24 : (i == PLL_25) ? BSD_REF_25 :
             (i == PLL_26) ? BSD_REF_26 : BSD_REF_RSVD;
         chk(pll_ref, e, "pll reference");
      end
      $display("test pll done");
   endtask

   task automatic t_pri;
      for (int i = 0; i < 16; i++)
      begin
         apply(mk(3'h3, i[3:0], 3'h7, 3'h0, 1'b0));
         chk(primary_src, i, "primary source");
      end
      $display("test primary done");
   endtask

   task automatic t_flash;
      for (int o = 0; o < 4; o++)
      begin
         apply(mk(3'h2, BSD_P_SNAND, o[2:0], 3'h0, 1'b0));
         chk(nand_lanes_log2, o[1] ? 0 : (o[0] ? 2 : 3), "nand");
         chk(nand_width_override, o[1], "nand override");
         chk(nand_wide_width_select, o[0] & ~o[1], "nand wide");
         apply(mk(3'h2, BSD_P_OSPI, o[2:0], 3'h0, 1'b0));
         chk(chip_select, o[0], "octal cs");
         apply(mk(3'h2, BSD_P_QSPI, o[2:0], 3'h0, 1'b0));
         chk(chip_select, o[0], "quad cs");
         apply(mk(3'h2, BSD_P_SPI, o[2:0], 3'h0, 1'b0));
         chk(chip_select, o[0], "spi cs");
         chk(spi_mode3, o[1], "spi mode");
      end
      $display("test flash done");
   endtask

   task automatic t_opts;
      for (int o = 0; o < 8; o++)
      begin
         apply(mk(3'h2, BSD_P_RGMII, o[2:0], 3'h0, 1'b0));
         chk(link_from_status, o[0], "rgmii link");
         apply(mk(3'h2, BSD_P_RMII, o[2:0], 3'h0, 1'b0));
         chk(reference_clock_output, o[2], "rmii clkout");
         chk(rmii_clock_source, o[1], "rmii source");
         apply(mk(3'h2, BSD_P_SD, o[2:0], 3'h0, 1'b0));
         chk(filesystem_or_raw_select, o[0], "sd mode");
         apply(mk(3'h2, BSD_P_I2C, o[2:0], 3'h0, 1'b0));
         chk(i2c_bus_reset_en, !o[2], "i2c bus reset");
         chk(i2c_target_addr, o[0] ? 8'h51 : 8'h50, "i2c addr");
         if (!o[2])
            chk(i2c_hung_cycles, 50000, "i2c delay");
         else
            chk(i2c_hung_cycles, 0, "i2c no delay");
         apply(mk(3'h2, BSD_P_USB, o[2:0], 3'h0, 1'b0));
         chk({usb_core_low_volt, usb_dfu, usb_lane_swap},
             {o[2], !o[1], o[0]}, "usb options");
         apply(mk(3'h2, BSD_P_XSPI, o[2:0], 3'h0, 1'b0));
         chk({xspi_discovery_en, xspi_ddr_mode}, {o[2], o[0]},
             "xspi");
         chk(xspi_read_opcode, o[1] ? 8'hEE : 8'h0B, "xspi op");
         apply(mk(3'h2, BSD_P_NOBOOT, o[2:0], 3'h0, 1'b0));
         chk({thumb_mode, no_boot}, {o[1], o[0]}, "dev boot");
      end
      $display("test options done");
   endtask

   // Options at all ones prove the backup defaults ignore bits 9 to 7.
   task automatic t_backup;
      for (int b = 0; b < 16; b++)
      begin
         apply(mk(3'h2, BSD_P_UART, 3'h7, b[2:0], b[3]));
         chk(backup_src, b[2:0], "backup source");
         chk(backup_opt, b[3], "backup option");
         chk(bak_clock_source, b[2:0] == BSD_B_ETH, "bak clksrc");
         chk({bak_chip_select, bak_spi_mode3, bak_i2c_addr_hi,
              bak_i2c_bus_reset_skip, bak_usb_low_volt, bak_usb_lane_swap,
              bak_link_from_status, bak_clock_output}, 0, "dflt");
      end
      $display("test backup done");
   endtask

   task automatic t_hold;
      apply(mk(3'h3, BSD_P_SPI, 3'h1, BSD_B_SPI, 1'b1));
      strap_set = mk(3'h4, BSD_P_USB, 3'h0, BSD_B_USB, 1'b0);
      repeat (6) step();
      chk(pll_ref, BSD_REF_25, "held pll");
      chk(primary_src, BSD_P_SPI, "held primary");
      chk(backup_src, BSD_B_SPI, "held backup");
      chk(chip_select, 1, "held cs");
      reset = 1'b1;
      repeat (2) step();
      chk(cfg_valid, 0, "valid in reset");
      chk(pll_ref, BSD_REF_RSVD, "pll in reset");
      apply(strap_set);
      chk(pll_ref, BSD_REF_26, "resampled pll");
      chk(primary_src, BSD_P_USB, "resampled src");
      $display("test hold done");
   endtask

   initial
   begin
      mclk = 1'b0;
      reset = 1'b1;
      strap_set = 14'h0000;
      fails = 0;
      samples_checked = 0;
      cycles = 0;
      t_pll();
      t_pri();
      t_flash();
      t_opts();
      t_backup();
      t_hold();
      end_of_test();
   end
endmodule // boot_strap_decoder_bench
